// >>> common/adcrg_pkg.sv
// Constants for the converter control and result register block.
// Assumes a single system clock and a plain strobe register port.
//
// Notes on behaviour
// - Each result is a ten-bit unsigned value.
// - Internal signals use the same single converter core.
// - Source select picks internal signal or external channel.
// - Channel select picks one of four external inputs.
// - At most one input reaches the core at once.
// - Format zero: left-justified, low byte upper bits.
// - Format one: right-justified, high byte two bits.
// - Unused result bits always read as zero.
// - Result registers are read-only; writes ignored.
// - Disabled converter keeps results unchanged.
// - Converter-selected pin loses its digital function.
// - Converter-selected pin loses its pull-high resistor.
// - Primary control: start, busy, enable, format, gain, channel.
// - Secondary control: source, gain, reference, clock select.
// - Start low-high-low begins conversion, sets busy.
// - Busy clears when the conversion finishes.
// - Channel codes four to seven select nothing.
package adcrg_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADCRG_OFF_RES_LOW  = 4'h0; // result_low_byte
   localparam logic [3:0] ADCRG_OFF_RES_HIGH = 4'h1; // result_high_byte
   localparam logic [3:0] ADCRG_OFF_CTRL_PRI = 4'h2; // converter_control_primary
   localparam logic [3:0] ADCRG_OFF_CTRL_SEC = 4'h3; // converter_control_secondary
   localparam logic [3:0] ADCRG_OFF_IRQ_STAT = 4'h4; // Sticky event status
   localparam logic [3:0] ADCRG_OFF_IRQ_MASK = 4'h5; // Event mask
   localparam logic [3:0] ADCRG_OFF_PIN_SEL  = 4'h6; // Pin analog selection

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ADCRG_P_START  = 7;
   localparam int ADCRG_P_BUSY   = 6;
   localparam int ADCRG_P_ENABLE = 5;
   localparam int ADCRG_P_FORMAT = 4;
   localparam int ADCRG_P_GAIN0  = 3;
   localparam int ADCRG_P_SRC    = 6;  // Secondary bits 7:6
   localparam int ADCRG_P_GAIN1  = 5;
   localparam int ADCRG_P_REF    = 3;  // Secondary bits 4:3
   localparam int ADCRG_P_CLK    = 0;  // Secondary bits 2:0
   localparam int ADCRG_EV_DONE  = 0;  // Status bit: conversion done
   localparam int ADCRG_EV_START = 1;  // Status bit: conversion started

   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [7:0] ADCRG_RST_BYTE  = 8'h00;
   localparam logic [9:0] ADCRG_RST_RES   = 10'h000;
   localparam int         ADCRG_RES_W     = 10;
   localparam int         ADCRG_NUM_EXT   = 4;
   localparam logic [1:0] ADCRG_SRC_EXT   = 2'h0; // Source code for external channel
   // Conversion time in ns, converted to cycles at 200 MHz
   localparam int ADCRG_CLK_NS    = 5;
   localparam int ADCRG_CONV_NS   = 80;
   localparam int ADCRG_CONV_CYC  = (ADCRG_CONV_NS + ADCRG_CLK_NS - 1) / ADCRG_CLK_NS;

   // Converter sequencer states
   typedef enum logic [1:0] {
      ADCRG_IDLE = 2'b00,
      ADCRG_CONV = 2'b01,
      ADCRG_LOAD = 2'b10
   } adcrg_state_t;
endpackage : adcrg_pkg

// >>> hdl/adcrg_top.sv
// Converter control and result registers with sequencer and interrupt.
// Assumes the analog core returns its code on core_data when core_done pulses.
`timescale 1ns/10ps
module adcrg_top (
   input  wire logic        clk,           // System clock, 200 MHz
   input  wire logic        rst,           // Synchronous reset, active high
   input  wire logic [3:0]  addr,          // Register address
   input  wire logic [7:0]  wdata,         // Write data
   input  wire logic        wr,            // Write strobe
   input  wire logic        rd,            // Read strobe
   output logic      [7:0]  rdata,         // Read data, one cycle after rd
   output logic             irq,           // Level interrupt
   output logic             core_start,    // Start pulse to analog core
   output logic             core_power,    // Power to analog core
   output logic      [1:0]  gain_select,   // Gain code to core
   output logic      [1:0]  reference_select, // Reference code
   output logic      [2:0]  conversion_clock_select, // Clock code
   output logic      [3:0]  ext_route,     // One-hot or zero external input route
   output logic      [1:0]  int_route,     // Internal source code, 0 when external
   input  wire logic        core_done,     // Completion pulse from core
   input  wire logic [9:0]  core_data,     // Result from core
   output logic      [3:0]  pin_analog,    // Pin converted to analog input
   output logic      [3:0]  pin_pullup_off // Pull-high forced off
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]          ctrl_pri;    // Primary control, busy bit unused here
   logic [7:0]          ctrl_sec;    // Secondary control
   logic [9:0]          result;      // Stored conversion result
   logic                busy;        // conversion_busy_flag
   logic                start_armed; // Start bit seen high
   logic [1:0]          irq_stat;    // Sticky events
   logic [1:0]          irq_mask;    // Event enables
   logic [3:0]          pin_sel;     // Pin analog select
   logic [7:0]          cnt;         // Conversion timer
   adcrg_pkg::adcrg_state_t state;   // Sequencer state
   adcrg_pkg::adcrg_state_t next_state;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   wire       wr_pri   = wr && hit(addr, adcrg_pkg::ADCRG_OFF_CTRL_PRI);
   wire       wr_sec   = wr && hit(addr, adcrg_pkg::ADCRG_OFF_CTRL_SEC);
   wire       wr_stat  = wr && hit(addr, adcrg_pkg::ADCRG_OFF_IRQ_STAT);
   wire       wr_mask  = wr && hit(addr, adcrg_pkg::ADCRG_OFF_IRQ_MASK);
   wire       wr_pin   = wr && hit(addr, adcrg_pkg::ADCRG_OFF_PIN_SEL);
   wire       enable   = ctrl_pri[adcrg_pkg::ADCRG_P_ENABLE];
   wire       fmt      = ctrl_pri[adcrg_pkg::ADCRG_P_FORMAT];
   wire [2:0] chan     = ctrl_pri[2:0];
   wire [1:0] src      = ctrl_sec[adcrg_pkg::ADCRG_P_SRC +: 2];
   // Start fires on falling edge of start bit after it was high
   wire       new_start = wr_pri && start_armed && !wdata[adcrg_pkg::ADCRG_P_START];
   wire       go        = new_start && enable && (state == adcrg_pkg::ADCRG_IDLE);
   wire       conv_end  = (state == adcrg_pkg::ADCRG_LOAD);

   // Result formatting
   wire [7:0] res_high = fmt ? {6'h00, result[9:8]}
                             : result[9:2];
   wire [7:0] res_low  = fmt ? result[7:0]
                             : {result[1:0], 6'h00};
   wire [7:0] pri_view = {ctrl_pri[7], busy, ctrl_pri[5:0]};

   // Read mux
   logic [7:0] next_rdata;
   always_comb begin
      case (addr)
         adcrg_pkg::ADCRG_OFF_RES_LOW:  next_rdata = res_low;
         adcrg_pkg::ADCRG_OFF_RES_HIGH: next_rdata = res_high;
         adcrg_pkg::ADCRG_OFF_CTRL_PRI: next_rdata = pri_view;
         adcrg_pkg::ADCRG_OFF_CTRL_SEC: next_rdata = ctrl_sec;
         adcrg_pkg::ADCRG_OFF_IRQ_STAT: next_rdata = {6'h00, irq_stat};
         adcrg_pkg::ADCRG_OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
         adcrg_pkg::ADCRG_OFF_PIN_SEL:  next_rdata = {4'h0, pin_sel};
         default:                       next_rdata = 8'h00; // Unmapped reads zero
      endcase
   end

   // ----------------------------------------------------------------
   // Input routing
   // ----------------------------------------------------------------
   // Only one source reaches the core; codes 4..7 route nothing
   genvar g;
   generate
      for (g = 0; g < adcrg_pkg::ADCRG_NUM_EXT; g++) begin : g_route
         assign ext_route[g] = (src == adcrg_pkg::ADCRG_SRC_EXT) && (chan == 3'(g));
      end
   endgenerate
   assign int_route = src;
   assign pin_analog     = pin_sel;
   assign pin_pullup_off = pin_sel;

   assign gain_select             = {ctrl_sec[adcrg_pkg::ADCRG_P_GAIN1],
                                     ctrl_pri[adcrg_pkg::ADCRG_P_GAIN0]};
   assign reference_select        = ctrl_sec[adcrg_pkg::ADCRG_P_REF +: 2];
   assign conversion_clock_select = ctrl_sec[adcrg_pkg::ADCRG_P_CLK +: 3];
   assign core_power              = enable;
   assign core_start              = go;
   assign irq                     = |(irq_stat & irq_mask);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         adcrg_pkg::ADCRG_IDLE: if (go) begin
            next_state = adcrg_pkg::ADCRG_CONV;
         end
         adcrg_pkg::ADCRG_CONV: if (!enable) begin
            next_state = adcrg_pkg::ADCRG_IDLE; // Abort, result untouched
         end else if (core_done || cnt == 8'(adcrg_pkg::ADCRG_CONV_CYC)) begin
            next_state = adcrg_pkg::ADCRG_LOAD;
         end
         adcrg_pkg::ADCRG_LOAD: next_state = adcrg_pkg::ADCRG_IDLE;
         default:               next_state = adcrg_pkg::ADCRG_IDLE;
      endcase
   end

   // Sequencer state and timer
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= adcrg_pkg::ADCRG_IDLE;
         cnt   <= 8'h00;
      end else begin
         state <= next_state;
         cnt   <= (state == adcrg_pkg::ADCRG_CONV) ? cnt + 8'h01 : 8'h00;
      end
   end

   // Busy flag: set on start, cleared on the same edge as the result load, or on abort
   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (go) begin
         busy <= 1'b1;
      end else if (conv_end || (state == adcrg_pkg::ADCRG_CONV && !enable)) begin
         busy <= 1'b0;
      end
   end

   // Result capture: both bytes in one edge, only while enabled
   logic [9:0] captured;
   always_ff @(posedge clk) begin
      if (rst) begin
         captured <= adcrg_pkg::ADCRG_RST_RES;
         result   <= adcrg_pkg::ADCRG_RST_RES;
      end else begin
         if (state == adcrg_pkg::ADCRG_CONV && core_done) begin
            captured <= core_data;
         end
         if (conv_end && enable) begin
            result <= captured;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_pri    <= adcrg_pkg::ADCRG_RST_BYTE;
         ctrl_sec    <= adcrg_pkg::ADCRG_RST_BYTE;
         start_armed <= 1'b0;
         pin_sel     <= 4'h0;
         irq_mask    <= 2'h0;
      end else begin
         if (wr_pri) begin
            ctrl_pri    <= {wdata[7], 1'b0, wdata[5:0]};
            start_armed <= wdata[adcrg_pkg::ADCRG_P_START];
         end
         if (wr_sec) begin
            ctrl_sec <= wdata;
         end
         if (wr_pin) begin
            pin_sel <= wdata[3:0];
         end
         if (wr_mask) begin
            irq_mask <= wdata[1:0];
         end
      end
   end

   // Sticky status: set wins over write-one-to-clear
   wire [1:0] ev = {go, conv_end};
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat <= 2'h0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_stat ? wdata[1:0] : 2'h0)) | ev;
      end
   end

   // Read data register
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_start_sets_busy: assert property (@(posedge clk) disable iff (rst)
      go |=> busy) else $error("busy not set after start");
   a_done_clears_busy: assert property (@(posedge clk) disable iff (rst)
      conv_end |=> !busy) else $error("busy not cleared at completion");
   a_result_before_clear: assert property (@(posedge clk) disable iff (rst)
      (conv_end && enable) |=> (result == $past(captured))) else $error("result not loaded");
   a_disabled_hold: assert property (@(posedge clk) disable iff (rst)
      !$past(enable) |-> $stable(result)) else $error("result changed while disabled");
   a_format_left: assert property (@(posedge clk) disable iff (rst)
      !fmt |-> (res_high == result[9:2] && res_low[5:0] == 6'h00)) else $error("left format");
   a_format_right: assert property (@(posedge clk) disable iff (rst)
      fmt |-> (res_high[7:2] == 6'h00 && res_low == result[7:0])) else $error("right format");
   a_one_route: assert property (@(posedge clk) disable iff (rst)
      $onehot0(ext_route)) else $error("route");
   a_no_route: assert property (@(posedge clk) disable iff (rst)
      (chan > 3'h3) |-> (ext_route == 4'h0)) else $error("route on empty code");
   a_pin_pullup: assert property (@(posedge clk) disable iff (rst)
      pin_analog == pin_pullup_off) else $error("pull-high kept on analog pin");
   a_read_latency: assert property (@(posedge clk) disable iff (rst)
      (rd && addr == adcrg_pkg::ADCRG_OFF_RES_LOW) |=> rdata == $past(res_low))
      else $error("read data wrong");


   // ----------------------------------------------------------------
   // Register view and routing checks
   // ----------------------------------------------------------------
   // Busy bit on a primary read shows the
   // flag as it stood when the read was taken
   a_busy_view: assert property (@(posedge clk) disable iff (rst)
      (rd && addr == adcrg_pkg::ADCRG_OFF_CTRL_PRI) |=> (rdata[6] == $past(busy)))
      else $error("busy bit view wrong");

   // An internal source leaves every
   // external input disconnected
   a_int_exclusive: assert property (@(posedge clk) disable iff (rst)
      (src != adcrg_pkg::ADCRG_SRC_EXT) |-> (ext_route == 4'h0))
      else $error("external route with internal source");

   // Internal code goes straight to the core
   // mux, zero meaning the external path
   a_int_follow: assert property (@(posedge clk) disable iff (rst)
      int_route == src)
      else $error("internal route wrong");

   // A valid channel code routes exactly
   // the matching external input
   a_ext_pick: assert property (@(posedge clk) disable iff (rst)
      (src == adcrg_pkg::ADCRG_SRC_EXT && chan < 3'h4)
      |-> (ext_route == (4'h1 << chan[1:0]))) else $error("wrong input routed");

   // Software writes to the result bytes
   // must never disturb the stored code
   a_write_ro: assert property (@(posedge clk) disable iff (rst)
      (wr && addr <= adcrg_pkg::ADCRG_OFF_RES_HIGH && !conv_end) |=> $stable(result))
      else $error("result changed by write");

   // Busy is set exactly while the
   // sequencer is away from idle
   a_busy_state: assert property (@(posedge clk) disable iff (rst)
      busy == (state != adcrg_pkg::ADCRG_IDLE))
      else $error("busy out of step with sequencer");

   // Core power follows the enable bit so a
   // disabled converter draws no current
   a_power_enable: assert property (@(posedge clk) disable iff (rst)
      core_power == enable)
      else $error("core power wrong");

   // Gain code joins the bit of each
   // control register
   a_gain_map: assert property (@(posedge clk) disable iff (rst)
      gain_select == {ctrl_sec[5], ctrl_pri[3]})
      else $error("gain code wrong");

   // Reference code comes from the
   // secondary register only
   a_ref_map: assert property (@(posedge clk) disable iff (rst)
      reference_select == ctrl_sec[4:3])
      else $error("reference code wrong");

   // Clock code comes from the low
   // secondary bits
   a_clk_map: assert property (@(posedge clk) disable iff (rst)
      conversion_clock_select == ctrl_sec[2:0])
      else $error("clock code wrong");

   // ----------------------------------------------------------------
   // Sequencer and event checks
   // ----------------------------------------------------------------
   // Completion always leaves its sticky
   // status bit set, even beside a clear
   a_done_event: assert property (@(posedge clk) disable iff (rst)
      conv_end |=> irq_stat[adcrg_pkg::ADCRG_EV_DONE])
      else $error("done event lost");

   // A start leaves its sticky status bit
   // set, even beside a clear
   a_start_event: assert property (@(posedge clk) disable iff (rst)
      go |=> irq_stat[adcrg_pkg::ADCRG_EV_START])
      else $error("start event lost");

   // A start only fires on the write that
   // brings the start bit back low
   a_start_low: assert property (@(posedge clk) disable iff (rst)
      go |-> !wdata[adcrg_pkg::ADCRG_P_START])
      else $error("start without low write");

   // The start bit must have been seen
   // high before the low write counts
   a_start_armed: assert property (@(posedge clk) disable iff (rst)
      go |-> start_armed)
      else $error("start without high write");

   // Disabling mid-conversion drops busy
   // at once and leaves the result alone
   a_abort_clears: assert property (@(posedge clk) disable iff (rst)
      (state == adcrg_pkg::ADCRG_CONV && !enable) |=> !busy)
      else $error("abort left busy set");

   // Timer never runs past the timeout,
   // so a silent core cannot hang busy
   a_conv_bound: assert property (@(posedge clk) disable iff (rst)
      (state == adcrg_pkg::ADCRG_CONV) |-> (cnt <= 8'(adcrg_pkg::ADCRG_CONV_CYC)))
      else $error("conversion timer overran");

   // Analog pins lose their digital role
   // exactly as selected
   a_pin_digital: assert property (@(posedge clk) disable iff (rst)
      pin_analog == pin_sel)
      else $error("pin role wrong");

   // Read data stands one cycle only and
   // is zero without a read
   a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
      !rd |=> (rdata == 8'h00))
      else $error("read data without read");

   // The result only moves at the load
   // step, so both bytes move together
   a_result_hold: assert property (@(posedge clk) disable iff (rst)
      !(conv_end && enable) |=> $stable(result))
      else $error("result moved outside load");

   // Load lasts a single cycle before
   // the sequencer returns to idle
   a_load_single: assert property (@(posedge clk) disable iff (rst)
      conv_end |=> (state == adcrg_pkg::ADCRG_IDLE))
      else $error("load step too long");

   // Busy still stands while the result
   // is being loaded
   a_busy_at_load: assert property (@(posedge clk) disable iff (rst)
      conv_end |-> busy)
      else $error("busy cleared before load");

   // Main scenarios reached
   c_conversion: cover property (@(posedge clk) disable iff (rst) go ##[1:40] conv_end);
   c_right_fmt: cover property (@(posedge clk) disable iff (rst) conv_end && fmt);
   c_timeout: cover property (@(posedge clk) disable iff (rst)
      state == adcrg_pkg::ADCRG_CONV && cnt == 8'(adcrg_pkg::ADCRG_CONV_CYC));
   c_abort: cover property (@(posedge clk) disable iff (rst) busy && !enable);
   c_irq: cover property (@(posedge clk) disable iff (rst) irq);
endmodule : adcrg_top

// >>> dv/tb_top.sv
// Self-checking bench for the converter control and result register block.
// Assumes the register port, the core handshake and the level interrupt.
`timescale 1ns/10ps
module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic       clk, rst, wr, rd, core_done;   // Clock, reset, strobes, core pulse
   logic [3:0] addr;                          // Register address
   logic [7:0] wdata, rdata;                  // Register data
   logic [9:0] core_data;                     // Code from the core
   logic       irq, core_start, core_power;   // Design outputs
   logic [1:0] gain_select, reference_select, int_route;
   logic [2:0] conversion_clock_select;
   logic [3:0] ext_route, pin_analog, pin_pullup_off;
   int         fails, n_checks, cyc, seed;    // Counters and seed
   logic       cs_seen;                       // Start pulse seen in last write
   logic [7:0] rv, r, p;                      // Read value, random bytes
   logic [9:0] d;                             // Conversion code
   logic       f;                             // Format bit

   adcrg_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .core_start(core_start), .core_power(core_power),
      .gain_select(gain_select), .reference_select(reference_select),
      .conversion_clock_select(conversion_clock_select), .ext_route(ext_route),
      .int_route(int_route), .core_done(core_done), .core_data(core_data),
      .pin_analog(pin_analog), .pin_pullup_off(pin_pullup_off));

   // Clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // One-cycle write; notes whether the core start pulse showed
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      #1 cs_seen = core_start;
      @(posedge clk);
      wr <= 1'b0;
      #1;                                     // Let the written register settle
   endtask : wr_reg

   // One-cycle read; data taken in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd_reg

   function automatic logic [7:0] exp_low(input logic [9:0] v, input logic fm);
      return fm ? v[7:0] : {v[1:0], 6'h00};
   endfunction : exp_low

   function automatic logic [7:0] exp_high(input logic [9:0] v, input logic fm);
      return fm ? {6'h00, v[9:8]} : v[9:2];
   endfunction : exp_high

   function automatic logic [3:0] exp_route(input logic [1:0] s, input logic [2:0] c);
      return (s == 2'h0 && c < 3'h4) ? 4'h1 << c[1:0] : 4'h0;
   endfunction : exp_route

   // Core finishes one cycle pulse, then the code line moves away
   task automatic core_finish(input logic [9:0] v);
      @(posedge clk);
      core_done <= 1'b1;
      core_data <= v;
      @(posedge clk);
      core_done <= 1'b0;
      core_data <= ~v;
      repeat (3) @(posedge clk);
   endtask : core_finish

   // Full conversion with start handshake and result readback
   task automatic conv(input logic [9:0] v, input logic fm, input logic [2:0] c);
      logic [7:0] ctl;
      ctl = {3'h1, fm, 1'b0, c};
      wr_reg(4'h2, ctl | 8'h80);
      check("start on set", 16'h0, 16'(cs_seen));
      wr_reg(4'h2, ctl);
      check("start on clear", 16'h1, 16'(cs_seen));
      rd_reg(4'h2);
      check("busy set", 16'h1, 16'(rv[6]));
      check("core power", 16'h1, 16'(core_power));
      core_finish(v);
      rd_reg(4'h2);
      check("busy clear", 16'h0, 16'(rv[6]));
      rd_reg(4'h0);
      check("result low", 16'(exp_low(v, fm)), 16'(rv));
      rd_reg(4'h1);
      check("result high", 16'(exp_high(v, fm)), 16'(rv));
   endtask : conv

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst, wr, rd, core_done, addr, wdata, core_data} = '0;
      rst  = 1'b1;
      seed = 16865;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Reset values, unmapped place included
      for (int a = 0; a < 8; a++) begin
         rd_reg(4'(a));
         check("reset value", 16'h0, 16'(rv));
      end
      // Control fields and input routing, every channel code
      for (int i = 0; i < 24; i++) begin
         r = 8'($random(seed));
         p = 8'($random(seed)) & 8'h3F;
         if (i < 8) begin
            r[7:6] = 2'h0;
            p[2:0] = 3'(i);
         end
         wr_reg(4'h3, r);
         wr_reg(4'h2, p);
         check("ext route", 16'(exp_route(r[7:6], p[2:0])), 16'(ext_route));
         check("int route", 16'(r[7:6]), 16'(int_route));
         check("gain", 16'({r[5], p[3]}), 16'(gain_select));
         check("ref sel", 16'(r[4:3]), 16'(reference_select));
         check("clk sel", 16'(r[2:0]), 16'(conversion_clock_select));
         rd_reg(4'h3);
         check("secondary", 16'(r), 16'(rv));
      end
      wr_reg(4'h3, 8'h00);
      wr_reg(4'h5, 8'h01);
      // Corner codes, then random ones
      conv(10'h3FF, 1'b0, 3'h0);
      conv(10'h3FF, 1'b1, 3'h1);
      conv(10'h001, 1'b0, 3'h2);
      conv(10'h200, 1'b1, 3'h3);
      for (int i = 0; i < 6; i++) begin
         d = 10'($random(seed));
         f = 1'($random(seed));
         conv(d, f, 3'($random(seed)));
      end
      // Events, mask and write-one clear
      rd_reg(4'h4);
      check("status", 16'h3, 16'(rv));
      check("irq on", 16'h1, 16'(irq));
      wr_reg(4'h5, 8'h00);
      @(negedge clk);
      check("irq masked", 16'h0, 16'(irq));
      wr_reg(4'h5, 8'h01);
      wr_reg(4'h4, 8'h03);
      rd_reg(4'h4);
      check("status clear", 16'h0, 16'(rv));
      check("irq off", 16'h0, 16'(irq));
      // Writes to result bytes are dropped
      wr_reg(4'h0, 8'hFF);
      wr_reg(4'h1, 8'hFF);
      rd_reg(4'h0);
      check("low after write", 16'(exp_low(d, f)), 16'(rv));
      // Disabled converter holds results
      wr_reg(4'h2, {3'h0, f, 4'h0});
      check("core power off", 16'h0, 16'(core_power));
      core_finish(~d);
      rd_reg(4'h1);
      check("high held", 16'(exp_high(d, f)), 16'(rv));
      // Pin analog selection
      r = 8'($random(seed));
      wr_reg(4'h6, r);
      check("pin analog", 16'(r[3:0]), 16'(pin_analog));
      check("pullup off", 16'(r[3:0]), 16'(pin_pullup_off));
      complete_run();
   end
endmodule : tb_top
